// *** src/xalu_core.sv ***
`timescale 1ns/1ps
`include "xalu_cfg.svh"

module xalu_core
  import xalu_pkg::*;
#(
  parameter int ADDR_W = 9
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // Decoder request
  input  wire logic              opValid,
  input  wire xalu_op_t          opCode,
  input  wire logic [2:0]        bitSel,
  input  wire logic [ADDR_W-1:0] opAddr,
  // Data memory read data for opAddr
  input  wire logic [7:0]        memRdata,
  // Data memory write port
  output logic                   memWe,
  output logic [ADDR_W-1:0]      memWaddr,
  output logic [7:0]             memWdata,
  // Architectural state
  output logic [7:0]             workReg,
  output logic [5:0]             flags,
  // Sequencer handshake
  output logic                   busy,
  output logic                   dummySlot
);

  logic [7:0]        work_r;
  logic [5:0]        flags_r;
  logic              memWe_r;
  logic [ADDR_W-1:0] memWaddr_r;
  logic [7:0]        memWdata_r;
  xalu_state_t       state_r;
  xalu_state_t       state_nxt;
  logic              skipTaken_r;
  logic              busy_r;
  logic              dummy_r;

  // Combinational result
  logic [7:0] res;
  logic       toMem;
  logic       toWork;
  logic [5:0] flagsNxt;
  logic       isSkip;
  logic       skipCond;
  logic [8:0] subFull;
  logic [4:0] subLow;
  logic [7:0] daaAdd;
  logic [8:0] daaSum;
  logic       cIn;
  logic       accept;

  assign cIn    = flags_r[`XALU_FLAG_C];
  // New ops only in idle, so the dummy slot can never write state
  assign accept = opValid && (state_r == XST_IDLE);

  always_comb begin
    res      = memRdata;
    toMem    = 1'b0;
    toWork   = 1'b0;
    flagsNxt = flags_r;
    isSkip   = 1'b0;
    skipCond = 1'b0;
    subFull  = {1'b0, work_r} - {1'b0, memRdata} - {8'h00, ~cIn};
    subLow   = {1'b0, work_r[3:0]} - {1'b0, memRdata[3:0]} - {4'h0, ~cIn};
    daaAdd   = 8'h00;
    if (work_r[3:0] > `XALU_NIBBLE_MAX || flags_r[`XALU_FLAG_AC]) begin
      daaAdd = daaAdd | `XALU_DAA_LO;
    end
    if (work_r[7:4] > `XALU_NIBBLE_MAX || cIn) begin
      daaAdd = daaAdd | `XALU_DAA_HI;
    end
    daaSum = {1'b0, work_r} + {1'b0, daaAdd};
    unique case (opCode)
      XOP_INV_MEM, XOP_INV_WORK: begin
        res = ~memRdata;
        toMem = (opCode == XOP_INV_MEM);
        toWork = !toMem;
        flagsNxt[`XALU_FLAG_Z] = (res == 8'h00);
      end
      XOP_DAA_MEM: begin
        res = daaSum[7:0];
        toMem = 1'b1;
        // Carry only ever set, so multi-byte chains keep a carry out
        flagsNxt[`XALU_FLAG_C] = cIn | daaSum[8] | daaAdd[6];
      end
      XOP_DEC_MEM, XOP_DEC_WORK: begin
        res = memRdata - 8'h01;
        toMem = (opCode == XOP_DEC_MEM);
        toWork = !toMem;
        flagsNxt[`XALU_FLAG_Z] = (res == 8'h00);
      end
      XOP_INC_MEM, XOP_INC_WORK: begin
        res = memRdata + 8'h01;
        toMem = (opCode == XOP_INC_MEM);
        toWork = !toMem;
        flagsNxt[`XALU_FLAG_Z] = (res == 8'h00);
      end
      XOP_MOV_TO_WORK: begin
        res = memRdata;
        toWork = 1'b1;
      end
      XOP_MOV_TO_MEM: begin
        res = work_r;
        toMem = 1'b1;
      end
      XOP_OR_WORK, XOP_OR_MEM: begin
        res = work_r | memRdata;
        toMem = (opCode == XOP_OR_MEM);
        toWork = !toMem;
        flagsNxt[`XALU_FLAG_Z] = (res == 8'h00);
      end
      XOP_RL_MEM, XOP_RL_WORK: begin
        res = {memRdata[6:0], memRdata[7]};
        toMem = (opCode == XOP_RL_MEM);
        toWork = !toMem;
      end
      XOP_RLC_MEM, XOP_RLC_WORK: begin
        res = {memRdata[6:0], cIn};
        toMem = (opCode == XOP_RLC_MEM);
        toWork = !toMem;
        flagsNxt[`XALU_FLAG_C] = memRdata[7];
      end
      XOP_RR_MEM, XOP_RR_WORK: begin
        res = {memRdata[0], memRdata[7:1]};
        toMem = (opCode == XOP_RR_MEM);
        toWork = !toMem;
      end
      XOP_RRC_MEM, XOP_RRC_WORK: begin
        res = {cIn, memRdata[7:1]};
        toMem = (opCode == XOP_RRC_MEM);
        toWork = !toMem;
        flagsNxt[`XALU_FLAG_C] = memRdata[0];
      end
      XOP_SBC_WORK, XOP_SBC_MEM: begin
        res = subFull[7:0];
        toMem = (opCode == XOP_SBC_MEM);
        toWork = !toMem;
        flagsNxt[`XALU_FLAG_C]  = !subFull[8];
        flagsNxt[`XALU_FLAG_AC] = !subLow[4];
        flagsNxt[`XALU_FLAG_Z]  = (res == 8'h00);
        flagsNxt[`XALU_FLAG_OV] = (work_r[7] != memRdata[7]) && (res[7] != work_r[7]);
        flagsNxt[`XALU_FLAG_SC] = res[7] ^ flagsNxt[`XALU_FLAG_OV];
        // Chained zero holds only if earlier bytes were zero too
        flagsNxt[`XALU_FLAG_CZ] = (res == 8'h00) && flags_r[`XALU_FLAG_CZ];
      end
      XOP_DSZ_MEM, XOP_DSZ_WORK: begin
        res = memRdata - 8'h01;
        toMem = (opCode == XOP_DSZ_MEM);
        toWork = !toMem;
        isSkip = 1'b1;
        skipCond = (res == 8'h00);
      end
      XOP_ISZ_MEM, XOP_ISZ_WORK: begin
        res = memRdata + 8'h01;
        toMem = (opCode == XOP_ISZ_MEM);
        toWork = !toMem;
        isSkip = 1'b1;
        skipCond = (res == 8'h00);
      end
      XOP_SET_MEM: begin
        res = `XALU_ALL_ONES;
        toMem = 1'b1;
      end
      XOP_SET_BIT: begin
        res = memRdata | (8'h01 << bitSel);
        toMem = 1'b1;
      end
      XOP_BIT_SKIP_NZ: begin
        isSkip = 1'b1;
        skipCond = memRdata[bitSel];
      end
      default: begin
        res = memRdata;
      end
    endcase
  end

  // Skip sequencing: issue, wait, dummy
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      XST_IDLE:  if (accept && isSkip) state_nxt = XST_WAIT;
      XST_WAIT:  state_nxt = XST_DUMMY;
      XST_DUMMY: state_nxt = XST_IDLE;
      default:   state_nxt = XST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r     <= XST_IDLE;
      skipTaken_r <= 1'b0;
      busy_r      <= 1'b0;
      dummy_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (accept) skipTaken_r <= isSkip && skipCond;
      busy_r  <= (state_nxt != XST_IDLE);
      // Dummy asserted only in third cycle of a taken skip
      dummy_r <= (state_nxt == XST_DUMMY) && (state_r == XST_WAIT) && skipTaken_r;
    end
  end

  // Architectural updates only on acceptance, never in the dummy slot
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      work_r  <= `XALU_WORK_RST;
      flags_r <= `XALU_FLAGS_RST;
    end else if (accept) begin
      if (toWork) work_r <= res;
      flags_r <= flagsNxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      memWe_r    <= 1'b0;
      memWaddr_r <= '0;
      memWdata_r <= 8'h00;
    end else begin
      memWe_r <= accept && toMem;
      if (accept) begin
        memWaddr_r <= opAddr;
        memWdata_r <= res;
      end
    end
  end

  assign workReg   = work_r;
  assign flags     = flags_r;
  assign memWe     = memWe_r;
  assign memWaddr  = memWaddr_r;
  assign memWdata  = memWdata_r;
  assign busy      = busy_r;
  assign dummySlot = dummy_r;

  // Assertions
  property p_skip_len;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && isSkip) |=> busy_r [*2] ##1 !busy_r;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip not three cycles");

  property p_dummy_quiet;
    @(posedge ref_clk) disable iff (!rstn)
      dummy_r |=> !memWe_r && $stable(work_r) && $stable(flags_r);
  endproperty
  a_dummy_quiet: assert property (p_dummy_quiet) else $error("dummy slot changed state");

  property p_inv;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_INV_WORK) |=> work_r == ~$past(memRdata) && !memWe_r;
  endproperty
  a_inv: assert property (p_inv) else $error("invert wrong");

  property p_inc_mem;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_INC_MEM) |=> memWe_r && memWdata_r == $past(memRdata) + 8'h01;
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("increment wrong");

  property p_mov_flags;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && (opCode == XOP_MOV_TO_WORK || opCode == XOP_RL_MEM || opCode == XOP_SET_MEM))
        |=> $stable(flags_r);
  endproperty
  a_mov_flags: assert property (p_mov_flags) else $error("flags changed");

  property p_rlc;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_RLC_WORK)
        |=> flags_r[0] == $past(memRdata[7]) && work_r[0] == $past(flags_r[0]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate carry wrong");

  property p_sbc_carry;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_SBC_WORK && work_r > memRdata) |=> flags_r[0];
  endproperty
  a_sbc_carry: assert property (p_sbc_carry) else $error("borrow carry wrong");

  property p_dsz_skip;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_DSZ_MEM && memRdata == 8'h01) |=> ##1 dummy_r;
  endproperty
  a_dsz_skip: assert property (p_dsz_skip) else $error("decrement skip missed");

  property p_bit_noskip;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_BIT_SKIP_NZ && !memRdata[bitSel]) |=> ##1 !dummy_r;
  endproperty
  a_bit_noskip: assert property (p_bit_noskip) else $error("bit skip wrong");

  property p_addr_pass;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && toMem) |=> memWe_r && memWaddr_r == $past(opAddr);
  endproperty
  a_addr_pass: assert property (p_addr_pass) else $error("write address altered");

  property p_inv_mem;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_INV_MEM) |=> memWe_r && memWdata_r == ~$past(memRdata) && $stable(work_r);
  endproperty
  a_inv_mem: assert property (p_inv_mem) else $error("invert to memory wrong");

  property p_daa_lo;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_DAA_MEM && (work_r[3:0] > `XALU_NIBBLE_MAX || flags_r[`XALU_FLAG_AC]))
        |=> memWdata_r[3:0] == $past(work_r[3:0]) + 4'h6;
  endproperty
  a_daa_lo: assert property (p_daa_lo) else $error("adjust low nibble wrong");

  // Low nibble left alone, so no carry spills into the high nibble
  property p_daa_hi;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_DAA_MEM && (work_r[7:4] > `XALU_NIBBLE_MAX || cIn)
        && work_r[3:0] <= `XALU_NIBBLE_MAX && !flags_r[`XALU_FLAG_AC])
        |=> memWdata_r[7:4] == $past(work_r[7:4]) + 4'h6;
  endproperty
  a_daa_hi: assert property (p_daa_hi) else $error("adjust high nibble wrong");

  property p_daa_flags;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_DAA_MEM)
        |=> flags_r[5:1] == $past(flags_r[5:1]) && (flags_r[`XALU_FLAG_C] || !$past(flags_r[`XALU_FLAG_C]));
  endproperty
  a_daa_flags: assert property (p_daa_flags) else $error("adjust touched other flags");

  property p_dec_work;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_DEC_WORK)
        |=> !memWe_r && work_r == $past(memRdata) - 8'h01 && flags_r[`XALU_FLAG_Z] == (work_r == 8'h00);
  endproperty
  a_dec_work: assert property (p_dec_work) else $error("decrement to work wrong");

  property p_or_mem;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_OR_MEM)
        |=> memWe_r && memWdata_r == ($past(work_r) | $past(memRdata)) && $stable(work_r);
  endproperty
  a_or_mem: assert property (p_or_mem) else $error("or to memory wrong");

  property p_rrc_mem;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_RRC_MEM)
        |=> memWdata_r == {$past(cIn), $past(memRdata[7:1])} && flags_r[`XALU_FLAG_C] == $past(memRdata[0]);
  endproperty
  a_rrc_mem: assert property (p_rrc_mem) else $error("rotate right carry wrong");

  property p_isz_mem;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && opCode == XOP_ISZ_MEM && memRdata == `XALU_ALL_ONES)
        |=> memWe_r && memWdata_r == 8'h00 && $stable(flags_r) ##1 dummy_r;
  endproperty
  a_isz_mem: assert property (p_isz_mem) else $error("increment skip missed");

  property p_skip_work;
    @(posedge ref_clk) disable iff (!rstn)
      (accept && (opCode == XOP_DSZ_WORK || opCode == XOP_ISZ_WORK))
        |=> !memWe_r ##1 dummy_r == (work_r == 8'h00);
  endproperty
  a_skip_work: assert property (p_skip_work) else $error("work skip decision wrong");

endmodule

// *** src/xalu_cfg.svh ***
`ifndef XALU_CFG_SVH
`define XALU_CFG_SVH
`define XALU_DAA_LO      8'h06
`define XALU_DAA_HI      8'h60
`define XALU_NIBBLE_MAX  4'h9
`define XALU_ALL_ONES    8'hFF
`define XALU_SKIP_CYCLES 2'h3
`define XALU_FLAG_C      0
`define XALU_FLAG_AC     1
`define XALU_FLAG_Z      2
`define XALU_FLAG_OV     3
`define XALU_FLAG_SC     4
`define XALU_FLAG_CZ     5
// Chained zero seeded set so the first byte of a chain decides it
`define XALU_FLAGS_RST   6'h20
`define XALU_WORK_RST    8'h00
`endif

// *** src/xalu_pkg.sv ***
package xalu_pkg;
  typedef enum logic [4:0] {
    XOP_NOP          = 5'h00,
    XOP_INV_MEM      = 5'h01,
    XOP_INV_WORK     = 5'h02,
    XOP_DAA_MEM      = 5'h03,
    XOP_DEC_MEM      = 5'h04,
    XOP_DEC_WORK     = 5'h05,
    XOP_INC_MEM      = 5'h06,
    XOP_INC_WORK     = 5'h07,
    XOP_MOV_TO_WORK  = 5'h08,
    XOP_MOV_TO_MEM   = 5'h09,
    XOP_OR_WORK      = 5'h0A,
    XOP_OR_MEM       = 5'h0B,
    XOP_RL_MEM       = 5'h0C,
    XOP_RL_WORK      = 5'h0D,
    XOP_RLC_MEM      = 5'h0E,
    XOP_RLC_WORK     = 5'h0F,
    XOP_RR_MEM       = 5'h10,
    XOP_RR_WORK      = 5'h11,
    XOP_RRC_MEM      = 5'h12,
    XOP_RRC_WORK     = 5'h13,
    XOP_SBC_WORK     = 5'h14,
    XOP_SBC_MEM      = 5'h15,
    XOP_DSZ_MEM      = 5'h16,
    XOP_DSZ_WORK     = 5'h17,
    XOP_SET_MEM      = 5'h18,
    XOP_SET_BIT      = 5'h19,
    XOP_ISZ_MEM      = 5'h1A,
    XOP_ISZ_WORK     = 5'h1B,
    XOP_BIT_SKIP_NZ  = 5'h1C
  } xalu_op_t;

  typedef enum logic [1:0] {
    XST_IDLE  = 2'b00,
    XST_WAIT  = 2'b01,
    XST_DUMMY = 2'b10
  } xalu_state_t;
endpackage

// *** verif/xalu_core_tb_top.sv ***
`timescale 1ns/1ps
`include "xalu_cfg.svh"

module xalu_core_tb_top
  import xalu_pkg::*;
;
  localparam int FC = `XALU_FLAG_C, FAC = `XALU_FLAG_AC, FZ = `XALU_FLAG_Z;
  localparam int FOV = `XALU_FLAG_OV, FSC = `XALU_FLAG_SC, FCZ = `XALU_FLAG_CZ;

  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       opValid = 1'b0;
  xalu_op_t   opCode = XOP_NOP;
  logic [2:0] bitSel = 3'h0;
  logic [8:0] opAddr = 9'h000;
  logic [7:0] memRdata = 8'h00;
  logic       memWe, busy, dummySlot;
  logic [8:0] memWaddr;
  logic [7:0] memWdata, workReg, eWork, eData;
  logic [5:0] flags, eFlags;
  logic       eWe, eSkip, isSkip;
  int         n_mismatch = 0;
  int         samples_checked = 0;

  always #4 ref_clk = ~ref_clk;

  xalu_core dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .opValid(opValid), .opCode(opCode), .bitSel(bitSel),
    .opAddr(opAddr), .memRdata(memRdata), .memWe(memWe), .memWaddr(memWaddr),
    .memWdata(memWdata), .workReg(workReg), .flags(flags), .busy(busy), .dummySlot(dummySlot)
  );

  task automatic chk(input string what, input logic [8:0] ev, input logic [8:0] gv);
    samples_checked++;
    if (gv !== ev) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, ev, gv);
    end
  endtask

  task automatic chkState(input logic b, input logic we, input logic dm);
    chk("workReg", {1'b0, eWork}, {1'b0, workReg});
    chk("flags", {3'h0, eFlags}, {3'h0, flags});
    chk("busy", {8'h00, b}, {8'h00, busy});
    chk("memWe", {8'h00, we}, {8'h00, memWe});
    chk("dummySlot", {8'h00, dm}, {8'h00, dummySlot});
  endtask

  task automatic model(input xalu_op_t op, input logic [7:0] m, input logic [2:0] bs);
    logic [7:0] r;
    logic [8:0] d;
    logic [4:0] lo;
    logic [7:0] adj;
    logic       c;
    logic       toWork;
    c = eFlags[FC];
    r = m;
    toWork = op inside {XOP_INV_WORK, XOP_DEC_WORK, XOP_INC_WORK, XOP_MOV_TO_WORK, XOP_OR_WORK, XOP_RL_WORK,
                        XOP_RLC_WORK, XOP_RR_WORK, XOP_RRC_WORK, XOP_SBC_WORK, XOP_DSZ_WORK, XOP_ISZ_WORK};
    case (op)
      XOP_INV_MEM, XOP_INV_WORK: r = ~m;
      XOP_DEC_MEM, XOP_DEC_WORK, XOP_DSZ_MEM, XOP_DSZ_WORK: r = m - 8'h01;
      XOP_INC_MEM, XOP_INC_WORK, XOP_ISZ_MEM, XOP_ISZ_WORK: r = m + 8'h01;
      XOP_MOV_TO_MEM: r = eWork;
      XOP_OR_WORK, XOP_OR_MEM: r = eWork | m;
      XOP_RL_MEM, XOP_RL_WORK: r = {m[6:0], m[7]};
      XOP_RLC_MEM, XOP_RLC_WORK: {eFlags[FC], r} = {m, c};
      XOP_RR_MEM, XOP_RR_WORK: r = {m[0], m[7:1]};
      XOP_RRC_MEM, XOP_RRC_WORK: {r, eFlags[FC]} = {c, m};
      XOP_SET_MEM: r = `XALU_ALL_ONES;
      XOP_SET_BIT: r = m | (8'h01 << bs);
      XOP_DAA_MEM: begin
        adj = {(eWork[7:4] > 4'h9 || c) ? 4'h6 : 4'h0, (eWork[3:0] > 4'h9 || eFlags[FAC]) ? 4'h6 : 4'h0};
        d = {1'b0, eWork} + {1'b0, adj};
        r = d[7:0];
        eFlags[FC] = c | d[8] | adj[5];
      end
      XOP_SBC_WORK, XOP_SBC_MEM: begin
        d = {1'b0, eWork} - {1'b0, m} - {8'h00, ~c};
        lo = {1'b0, eWork[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
        r = d[7:0];
        eFlags[FC] = ~d[8];
        eFlags[FAC] = ~lo[4];
        eFlags[FOV] = (eWork[7] != m[7]) && (r[7] != eWork[7]);
        eFlags[FSC] = r[7] ^ eFlags[FOV];
        eFlags[FCZ] = (r == 8'h00) & eFlags[FCZ];
      end
      default: r = m;
    endcase
    if (op inside {XOP_INV_MEM, XOP_INV_WORK, XOP_DEC_MEM, XOP_DEC_WORK, XOP_INC_MEM, XOP_INC_WORK,
                   XOP_OR_WORK, XOP_OR_MEM, XOP_SBC_WORK, XOP_SBC_MEM}) eFlags[FZ] = (r == 8'h00);
    isSkip = op inside {XOP_DSZ_MEM, XOP_DSZ_WORK, XOP_ISZ_MEM, XOP_ISZ_WORK, XOP_BIT_SKIP_NZ};
    eSkip = (op == XOP_BIT_SKIP_NZ) ? m[bs] : (isSkip && r == 8'h00);
    eWe = !toWork && !(op inside {XOP_NOP, XOP_BIT_SKIP_NZ});
    eData = r;
    if (toWork) eWork = r;
  endtask

  // Address walks through every section so no bank limit can hide
  task automatic run(input xalu_op_t op, input logic [7:0] m, input logic [2:0] bs = 3'h0);
    model(op, m, bs);
    @(posedge ref_clk);
    opValid  <= 1'b1;
    opCode   <= op;
    bitSel   <= bs;
    opAddr   <= opAddr + 9'h0B7;
    memRdata <= m;
    @(posedge ref_clk);
    // Skips keep a stray write request up in the wait cycle; it must be ignored
    opValid  <= isSkip;
    opCode   <= XOP_SET_MEM;
    memRdata <= ~m;
    #1;
    chkState(isSkip, eWe, 1'b0);
    if (eWe) chk("memWaddr", opAddr, memWaddr);
    if (eWe) chk("memWdata", {1'b0, eData}, {1'b0, memWdata});
    if (isSkip) begin
      @(posedge ref_clk);
      opValid <= 1'b0;
      #1;
      chkState(1'b1, 1'b0, eSkip);
      @(posedge ref_clk);
      #1;
      chkState(1'b0, 1'b0, 1'b0);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    eWork = `XALU_WORK_RST;
    eFlags = `XALU_FLAGS_RST;
    repeat (15) @(posedge ref_clk);
    #1;
    chkState(1'b0, 1'b0, 1'b0);
    @(posedge ref_clk);
    rstn <= 1'b1;
    run(XOP_MOV_TO_WORK, 8'h3C);
    run(XOP_MOV_TO_MEM, 8'h00);
    run(XOP_INV_MEM, 8'hFF);
    run(XOP_INV_WORK, 8'h5A);
    run(XOP_INC_MEM, 8'hFF);
    run(XOP_INC_WORK, 8'h7F);
    run(XOP_DEC_MEM, 8'h01);
    run(XOP_DEC_WORK, 8'h00);
    run(XOP_MOV_TO_WORK, 8'h00);
    run(XOP_OR_MEM, 8'h00);
    run(XOP_OR_WORK, 8'h81);
    run(XOP_RL_MEM, 8'h81);
    run(XOP_RL_WORK, 8'h80);
    run(XOP_RLC_MEM, 8'h80);
    run(XOP_RLC_WORK, 8'h01);
    run(XOP_RR_MEM, 8'h01);
    run(XOP_RR_WORK, 8'h02);
    run(XOP_RRC_MEM, 8'h01);
    run(XOP_RRC_WORK, 8'h00);
    run(XOP_SBC_WORK, 8'h01);
    run(XOP_SBC_MEM, 8'h7E);
    run(XOP_MOV_TO_WORK, 8'h10);
    run(XOP_SBC_WORK, 8'h20);
    run(XOP_DAA_MEM, 8'h00);
    run(XOP_MOV_TO_WORK, 8'h00);
    run(XOP_SBC_WORK, 8'h01);
    run(XOP_MOV_TO_WORK, 8'h4A);
    run(XOP_DAA_MEM, 8'h00);
    run(XOP_MOV_TO_WORK, 8'hA3);
    run(XOP_DAA_MEM, 8'h00);
    run(XOP_DSZ_MEM, 8'h01);
    run(XOP_ISZ_MEM, 8'hFF);
    run(XOP_ISZ_WORK, 8'h10);
    run(XOP_DSZ_WORK, 8'h01);
    run(XOP_SET_MEM, 8'h12);
    run(XOP_SET_BIT, 8'h00, 3'h7);
    run(XOP_BIT_SKIP_NZ, 8'h08, 3'h3);
    run(XOP_BIT_SKIP_NZ, 8'hF7, 3'h3);
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(posedge ref_clk);
    #1;
    eWork = `XALU_WORK_RST;
    eFlags = `XALU_FLAGS_RST;
    chkState(1'b0, 1'b0, 1'b0);
    @(posedge ref_clk);
    rstn <= 1'b1;
    // Zero result with the chain still seeded keeps chained zero set
    run(XOP_SBC_WORK, 8'hFF);
    run(XOP_INC_WORK, 8'h41);
    print_verdict();
  end

  initial begin
    repeat (4000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
